// [logic/cdus_pkg.sv]
package cdus_pkg;

  // register byte addresses; printed offsets are not word aligned, so own map
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] DATAH_ADDR  = 4'h4;
  localparam logic [3:0] DATAL_ADDR  = 4'h8;
  localparam logic [3:0] STATUS_ADDR = 4'hC;
  localparam int         ADDR_W      = 4;

  // control and low data byte field positions
  localparam int EN_BIT    = 7;
  localparam int SRC_LSB   = 4;
  localparam int FS_LSB    = 0;
  localparam int LOW_LSB   = 6;

  // values after reset
  localparam logic [2:0] SRC_RESET  = 3'h7;
  localparam logic [1:0] FS_RESET   = 2'h2;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // update source encodings
  typedef enum logic [2:0] {
    CDUS_SRC_T0    = 3'h0,
    CDUS_SRC_T1    = 3'h1,
    CDUS_SRC_T2    = 3'h2,
    CDUS_SRC_T3    = 3'h3,
    CDUS_SRC_RISE  = 3'h4,
    CDUS_SRC_FALL  = 3'h5,
    CDUS_SRC_ANY   = 3'h6,
    CDUS_SRC_WRITE = 3'h7
  } cdus_src_t;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register image
  typedef struct packed {
    logic      enable;
    cdus_src_t src;
    logic [1:0] fs;
  } cdus_ctrl_t;

  // converter-facing bundle
  typedef struct packed {
    logic [9:0] code;
    logic [1:0] fs;
    logic       bias_en;
    logic       pin_analog;
  } cdus_conv_t;

endpackage : cdus_pkg

// [logic/cdus_edge_sync.sv]
// two-flop synchroniser plus edge detect for the conversion-start pin
module cdus_edge_sync (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and detected edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // first flop only feeds the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edges seen on the synchronised level only
  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule : cdus_edge_sync

// [logic/cdus_top.sv]
// What this block does
// RULE_01: hold a 10-bit word split over high and low bytes, drive to converter
// RULE_02: enable clear leaves the converter pin as ordinary general-purpose I/O
// RULE_03: enable set kills pin drivers and pull-up, connects converter output
// RULE_04: bias reference enable follows the converter enable bit
// RULE_05: source 111 updates the input latch on a high-byte write
// RULE_06: in write mode low-byte writes are buffered until a high-byte write
// RULE_07: software writes low byte first, then high byte, for full resolution
// RULE_08: 8-bit use: set low byte once, then write only the high byte
// RULE_09: sources 000 to 011 hold data until timer 0 to 3 overflow
// RULE_10: on the chosen timer overflow copy both bytes into the latch together
// RULE_11: sources 100, 101, 110 wait for rising, falling, either start-pin edge
// RULE_12: on the chosen start-pin edge copy both bytes into the latch together
// RULE_13: software sets port 0 skip bit 1 while the converter is used
// RULE_14: data is left-justified: high byte msbs, low byte bits 7:6 lsbs
// RULE_15: low byte bits 5:0 read zero and ignore writes
// RULE_16: full-scale 00 half mA, 01 one mA, 1x two mA, default two
// RULE_17: start pin synchronised before edge detect; timer overflow is one-cycle pulse
// RULE_18: update events copy into the latch even while the converter is disabled
module cdus_top (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write address
  input  wire logic [cdus_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read address
  input  wire logic [cdus_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // update events
  input  wire logic [3:0]                    timer_overflow,
  input  wire logic                          external_convert_start,
  // converter and pin control
  output cdus_pkg::cdus_conv_t               conv,
  output logic                               gpio_enable
);

  cdus_pkg::cdus_ctrl_t ctrl_r;
  logic [7:0]           high_r;
  logic [1:0]           low_r;
  logic [9:0]           latch_r;
  logic                 upd_pending_r;
  logic                 aw_hold_r;
  logic                 w_hold_r;
  logic [cdus_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0]          wdata_r;
  logic [3:0]           wstrb_r;
  logic                 cnv_rise;
  logic                 cnv_fall;
  logic                 wr_fire;
  logic                 wr_high;
  logic                 timer_hit;
  logic                 edge_hit;
  logic                 update;
  logic [cdus_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic [31:0]          rd_word;
  logic                 rd_ok;

  // conversion-start pin crossing
  cdus_edge_sync u_sync ( // RULE_17
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (external_convert_start),
    .rise    (cnv_rise),
    .fall    (cnv_fall)
  );

  // address and data may arrive in either order; hold each until both seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= '0;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end
  end

  // ready only while a slot is free and no response is owed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid && !wr_fire;
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid && !wr_fire;
    end
  end

  // a write completes once address and data are both in hand
  always_comb begin
    wr_fire = aw_hold_r && w_hold_r;
    wr_addr = awaddr_r;
    wr_data = wdata_r;
    wr_strb = wstrb_r;
  end

  // write response, slverr on any address but control, data high and data low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= cdus_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_addr == cdus_pkg::CTRL_ADDR || wr_addr == cdus_pkg::DATAH_ADDR
                       || wr_addr == cdus_pkg::DATAL_ADDR) ? cdus_pkg::RESP_OKAY
                                                           : cdus_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register; byte lane 0 carries it, bits 3:2 unused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.enable <= 1'b0;
      ctrl_r.src    <= cdus_pkg::cdus_src_t'(cdus_pkg::SRC_RESET);
      ctrl_r.fs     <= cdus_pkg::FS_RESET; // RULE_16
    end else if (wr_fire && wr_addr == cdus_pkg::CTRL_ADDR && wr_strb[0]) begin
      ctrl_r.enable <= wr_data[cdus_pkg::EN_BIT];
      ctrl_r.src    <= cdus_pkg::cdus_src_t'(wr_data[cdus_pkg::SRC_LSB +: 3]);
      ctrl_r.fs     <= wr_data[cdus_pkg::FS_LSB +: 2];
    end
  end

  // buffered data bytes; only bits 7:6 of the low byte are kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_r <= cdus_pkg::DATA_RESET;
      low_r  <= 2'b00;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_addr == cdus_pkg::DATAH_ADDR) begin
        high_r <= wr_data[7:0]; // RULE_01
      end
      if (wr_addr == cdus_pkg::DATAL_ADDR) begin
        low_r <= wr_data[cdus_pkg::LOW_LSB +: 2]; // RULE_15
      end
    end
  end

  // update event selection
  always_comb begin
    wr_high   = wr_fire && wr_strb[0] && wr_addr == cdus_pkg::DATAH_ADDR;
    timer_hit = 1'b0;
    edge_hit  = 1'b0;
    unique case (ctrl_r.src)
      cdus_pkg::CDUS_SRC_T0,
      cdus_pkg::CDUS_SRC_T1,
      cdus_pkg::CDUS_SRC_T2,
      cdus_pkg::CDUS_SRC_T3:   timer_hit = timer_overflow[ctrl_r.src[1:0]]; // RULE_09
      cdus_pkg::CDUS_SRC_RISE: edge_hit  = cnv_rise; // RULE_11
      cdus_pkg::CDUS_SRC_FALL: edge_hit  = cnv_fall; // RULE_11
      cdus_pkg::CDUS_SRC_ANY:  edge_hit  = cnv_rise | cnv_fall; // RULE_11
      cdus_pkg::CDUS_SRC_WRITE: begin
        timer_hit = 1'b0;
        edge_hit  = 1'b0;
      end
    endcase
  end

  // write mode latches after the high byte has landed, one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_pending_r <= 1'b0;
    end else begin
      upd_pending_r <= wr_high && ctrl_r.src == cdus_pkg::CDUS_SRC_WRITE; // RULE_05 RULE_06
    end
  end

  // events act whatever the enable state, so the latch is current at enable
  assign update = upd_pending_r || timer_hit || edge_hit; // RULE_18

  // converter input latch, both bytes copied together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= 10'h000;
    end else if (update) begin
      latch_r <= {high_r, low_r}; // RULE_10 RULE_12 RULE_14
    end
  end

  // converter and pin outputs, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // full scale shows its reset value from the first edge in reset, not only one edge after release
      conv.code       <= 10'h000;
      conv.fs         <= cdus_pkg::FS_RESET; // RULE_16
      conv.bias_en    <= 1'b0;
      conv.pin_analog <= 1'b0;
      gpio_enable     <= 1'b1;
    end else begin
      conv.code       <= latch_r; // RULE_01
      conv.fs         <= ctrl_r.fs; // RULE_16
      conv.bias_en    <= ctrl_r.enable; // RULE_04
      conv.pin_analog <= ctrl_r.enable; // RULE_03
      gpio_enable     <= !ctrl_r.enable; // RULE_02
    end
  end

  // read word decode; status shows the live latch and the enable
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      cdus_pkg::CTRL_ADDR:   rd_word = {24'h00_0000, ctrl_r.enable, ctrl_r.src, 2'b00,
                                        ctrl_r.fs};
      cdus_pkg::DATAH_ADDR:  rd_word = {24'h00_0000, high_r};
      cdus_pkg::DATAL_ADDR:  rd_word = {24'h00_0000, low_r, 6'b00_0000}; // RULE_15
      cdus_pkg::STATUS_ADDR: rd_word = {21'h00_0000, ctrl_r.enable, latch_r};
      default:               rd_ok   = 1'b0;
    endcase
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cdus_pkg::RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? cdus_pkg::RESP_OKAY : cdus_pkg::RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : cdus_top

// [verification/cdus_props.sv]
module cdus_props (
  // clock and reset
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // register bus handshakes
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  // update events and converter side
  input wire logic [3:0]           timer_overflow,
  input wire logic                 external_convert_start,
  input wire cdus_pkg::cdus_conv_t conv,
  input wire logic                 gpio_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [3:0] idle_r;
  logic       pin_q_r;

  // previous pin level, to spot any change of the start pin
  always_ff @(posedge aclk) begin
    pin_q_r <= external_convert_start;
  end

  // cycles since the last possible update cause; saturates so it never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn || (|timer_overflow) || s_axi_bvalid || pin_q_r != external_convert_start) begin
      idle_r <= 4'h0;
    end else if (idle_r != 4'hf) begin
      idle_r <= idle_r + 4'h1;
    end
  end

  pin_a: assert property (gpio_enable != conv.pin_analog)
    else $error("pin owner and analog connect disagree");
  bias_a: assert property (conv.bias_en == conv.pin_analog)
    else $error("bias enable not following converter enable");
  quiet_a: assert property (idle_r > 4'h8 |-> $stable(conv.code))
    else $error("converter code moved without an update event");
  wlat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rlat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bblk_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rblk_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  bone_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rone_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");

  cover property (|timer_overflow ##1 $changed(conv.code));
  cover property ($rose(gpio_enable));
  cover property ($changed(external_convert_start) ##[1:8] $changed(conv.code));
endmodule : cdus_props

bind cdus_top cdus_props cdus_props_i (.*);

// [verification/cdus_top_tb.sv]
module cdus_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext;
  logic awready, wready, bvalid, arready, rvalid, gpio_en;
  logic [3:0] awaddr, araddr, wstrb, tmr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [9:0] exp;
  cdus_pkg::cdus_conv_t conv;
  int errors, n_checks;

  cdus_top cdus_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timer_overflow(tmr), .external_convert_start(ext), .conv(conv),
    .gpio_enable(gpio_en));

  task automatic finish_test();
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // bus tasks are entered just after a rising edge; bready and rready stay high
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    logic dn;
    dn = 0;
    awaddr <= a; wdata <= {24'h00_0000, d}; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        dn = 1;
        chk("bresp", 32'h0, {30'h0, bresp});
      end
    end
    if (!dn) begin
      errors++;
      finish_test();
    end
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic dn;
    dn = 0;
    araddr <= a; arvalid <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        dn = 1;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
    if (!dn) begin
      errors++;
      finish_test();
    end
  endtask : rchk

  task automatic code_is(input int w);
    repeat (w) @(posedge aclk);
    chk("code", {22'h0, exp}, {22'h0, conv.code});
  endtask : code_is

  task automatic pulse(input logic [3:0] m);
    tmr <= m;
    @(posedge aclk);
    tmr <= 4'h0;
    @(posedge aclk);
  endtask : pulse

  task automatic t_reset();
    rchk(cdus_pkg::CTRL_ADDR, 32'h0000_0072);
    rchk(cdus_pkg::STATUS_ADDR, 32'h0000_0000);
    chk("gpio", 32'h1, {31'h0, gpio_en});
    chk("bias", 32'h0, {31'h0, conv.bias_en});
    chk("fs", 32'h2, {30'h0, conv.fs});
  endtask : t_reset

  task automatic t_write();
    exp = 10'h000;
    wr(cdus_pkg::DATAL_ADDR, 8'hff);
    code_is(4);
    rchk(cdus_pkg::DATAL_ADDR, 32'h0000_00c0);
    wr(cdus_pkg::DATAH_ADDR, 8'ha5);
    exp = 10'h297;
    code_is(4);
    wr(cdus_pkg::DATAH_ADDR, 8'h12, 4'he); // masked byte lane leaves all alone
    code_is(4);
    wr(cdus_pkg::DATAH_ADDR, 8'h12);
    exp = 10'h04b;
    code_is(4);
    rchk(cdus_pkg::STATUS_ADDR, 32'h0000_004b);
    rchk(4'h2, 32'h0000_0000, cdus_pkg::RESP_SLVERR);
  endtask : t_write

  task automatic t_timer();
    for (int n = 0; n < 4; n++) begin
      wr(cdus_pkg::CTRL_ADDR, {n[0], n[2:0], 2'b11, n[1:0]});
      rchk(cdus_pkg::CTRL_ADDR, {24'h00_0000, n[0], n[2:0], 2'b00, n[1:0]});
      wr(cdus_pkg::DATAH_ADDR, 8'h40 + n[7:0]);
      wr(cdus_pkg::DATAL_ADDR, 8'h80);
      pulse(~(4'h1 << n));
      code_is(3);
      pulse(4'h1 << n);
      exp = {8'h40 + n[7:0], 2'b10};
      code_is(3);
      chk("gpio", {31'h0, !n[0]}, {31'h0, gpio_en});
      chk("bias", {31'h0, n[0]}, {31'h0, conv.bias_en});
      chk("fs", {30'h0, n[1:0]}, {30'h0, conv.fs});
    end
  endtask : t_timer

  // rise then fall for each edge mode; only matching edges may move the code
  task automatic t_edge();
    for (int m = 4; m < 7; m++) begin
      wr(cdus_pkg::CTRL_ADDR, {1'b1, m[2:0], 4'h2});
      for (int k = 0; k < 2; k++) begin
        wr(cdus_pkg::DATAH_ADDR, {m[3:0], k[1:0], 2'b01});
        wr(cdus_pkg::DATAL_ADDR, 8'h40);
        ext <= !ext;
        if (m == 6 || m[0] == k[0]) exp = {m[3:0], k[1:0], 4'h5};
        code_is(8);
      end
    end
  endtask : t_edge

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // main sequence
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0; ext = 1'b0;
    bready = 1'b1; rready = 1'b1; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0;
    tmr = 4'h0; wdata = 32'h0000_0000; errors = 0; n_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_write();
    t_timer();
    t_edge();
    finish_test();
  end
endmodule : cdus_top_tb
